/* File: rtl/ecsl_consts.svh */
// Constants of the engine command/status link: timing, field positions, codes.
// Assumes a 25 ns core clock; included by every end of the link.
`ifndef ECSL_CONSTS_SVH
`define ECSL_CONSTS_SVH

`define ECSL_CLK_NS         25
`define ECSL_SCLK_MIN_NS    2000
`define ECSL_SCLK_MAX_NS    16000
`define ECSL_LINE600_NS     361820
`define ECSL_LINE1200_NS    180910
`define ECSL_LINE_PULSE_CYC 4
`define ECSL_BYTE_BITS      4'h8
`define ECSL_CMD_MAX_BYTES  3'h5
`define ECSL_DATA_MARK_BIT  7
`define ECSL_REPLY_ZERO     6'h00
`define ECSL_REPLY_ERR      6'h3f
`define ECSL_RETRY_MAX      2'h3

`endif

/* File: rtl/ecsl_pkg.sv */
// Types shared by both ends of the engine command/status link.
// Assumes nothing beyond a SystemVerilog compiler.
package ecsl_pkg;

  typedef enum logic [2:0] {
    eng_idle,
    eng_rx,
    eng_decode,
    eng_reply_wait,
    eng_reply
  } ecsl_eng_st_e;

  typedef enum logic [2:0] {
    ctl_idle,
    ctl_wait_free,
    ctl_send,
    ctl_wait_reply,
    ctl_recv,
    ctl_check
  } ecsl_ctl_st_e;

endpackage

/* File: rtl/ecsl_link_if.sv */
// Pin bundle between print engine and print controller.
// All lines are one-way; names ending in _n are active low.
`timescale 1ns/1ps
interface ecsl_link_if;
  logic serial_clock;
  logic command_line;
  logic reply_line;
  logic controller_command_busy_n;
  logic engine_reply_busy_n;
  logic host_power_up_done_n;
  logic engine_power_up_done_n;
  logic print_accept_n;
  logic paper_prefeed_request_n;
  logic print_go_n;
  logic line_sync_n;

  modport engine (
    input  serial_clock, command_line, controller_command_busy_n, host_power_up_done_n,
    input  paper_prefeed_request_n, print_go_n,
    output reply_line, engine_reply_busy_n, engine_power_up_done_n, print_accept_n,
    output line_sync_n
  );

  modport ctrl (
    output serial_clock, command_line, controller_command_busy_n, host_power_up_done_n,
    output paper_prefeed_request_n, print_go_n,
    input  reply_line, engine_reply_busy_n, engine_power_up_done_n, print_accept_n,
    input  line_sync_n
  );
endinterface

/* File: rtl/ecsl_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin inputs.
// Only the second flop of each bit is visible outside.
`timescale 1ns/1ps
module ecsl_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        meta_ff[g] <= RST_VAL[g];
        sync_ff[g] <= RST_VAL[g];
      end else begin
        meta_ff[g] <= i_async[g];
        sync_ff[g] <= meta_ff[g];
      end
    end
  end

  assign o_sync = sync_ff;
endmodule // ecsl_sync

/* File: rtl/ecsl_engine.sv */
// Engine end of the command/status link: receives commands, answers replies,
// drives print-accept and line-sync. Link pins come from another clock domain.
`timescale 1ns/1ps
`include "ecsl_consts.svh"
module ecsl_engine #(
  parameter int LINE_600_CYC  = `ECSL_LINE600_NS / `ECSL_CLK_NS,
  parameter int LINE_1200_CYC = `ECSL_LINE1200_NS / `ECSL_CLK_NS
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  ecsl_link_if.engine      link,
  input  wire logic        i_engine_ready,
  input  wire logic        i_operator_call,
  input  wire logic        i_pause_diag,
  input  wire logic        i_wait,
  input  wire logic        i_misprint,
  input  wire logic        i_dpi_1200,
  input  wire logic [2:0]  i_hdr_len,
  input  wire logic [5:0]  i_hdr_reply,
  input  wire logic        i_hdr_bad_use,
  output logic      [7:0]  o_cmd_hdr,
  output logic      [23:0] o_cmd_data,
  output logic             o_cmd_valid,
  output logic             o_prefeed,
  output logic             o_print_go
);
  if (LINE_600_CYC > 65535 || LINE_1200_CYC < 2 * `ECSL_LINE_PULSE_CYC) begin : g_chk
    $error("ecsl_engine: line period out of range");
  end

  // Synchronised pins
  logic sclk_s;
  logic cmd_s;
  logic controller_command_busy_s;
  logic hpw_s;
  logic paper_prefeed_request_s;
  logic go_s;

  ecsl_sync #(.WIDTH(6), .RST_VAL(6'h3f)) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_async    ({link.serial_clock, link.command_line, link.controller_command_busy_n,
                  link.host_power_up_done_n, link.paper_prefeed_request_n,
                  link.print_go_n}),
    .o_sync     ({sclk_s, cmd_s, controller_command_busy_s, hpw_s, paper_prefeed_request_s, go_s})
  );

  // Link state
  ecsl_pkg::ecsl_eng_st_e st_ff;
  ecsl_pkg::ecsl_eng_st_e nxt_st;
  logic [7:0]  sh_ff;
  logic [7:0]  nxt_sh;
  logic [3:0]  bit_ff;
  logic [3:0]  nxt_bit;
  logic [2:0]  idx_ff;
  logic [2:0]  nxt_idx;
  logic [2:0]  need_ff;
  logic [2:0]  nxt_need;
  logic        err_ff;
  logic        nxt_err;
  logic [7:0]  hdr_ff;
  logic [7:0]  nxt_hdr;
  logic [23:0] data_ff;
  logic [23:0] nxt_data;
  logic [7:0]  rep_ff;
  logic [7:0]  nxt_rep;
  logic        valid_ff;
  logic        nxt_valid;
  logic        sclk_q_ff;
  logic        rise;
  logic        fall;
  logic        bad;
  logic        last;
  logic [5:0]  pay;

  assign rise = sclk_s & ~sclk_q_ff;
  assign fall = ~sclk_s & sclk_q_ff;

  always_comb begin
    nxt_st    = st_ff;
    nxt_sh    = sh_ff;
    nxt_bit   = bit_ff;
    nxt_idx   = idx_ff;
    nxt_need  = need_ff;
    nxt_err   = err_ff;
    nxt_hdr   = hdr_ff;
    nxt_data  = data_ff;
    nxt_rep   = rep_ff;
    nxt_valid = 1'b0;
    bad       = 1'b0;
    last      = 1'b0;
    pay       = `ECSL_REPLY_ZERO;
    case (st_ff)
      ecsl_pkg::eng_idle: begin
        if (!controller_command_busy_s) begin
          nxt_bit = 4'h0;
          nxt_st  = ecsl_pkg::eng_rx;
        end
      end
      ecsl_pkg::eng_rx: begin
        if (controller_command_busy_s) begin
          if (idx_ff == 3'h0) begin
            nxt_hdr = sh_ff;
          end
          nxt_st = ecsl_pkg::eng_decode;
        end else if (rise) begin
          nxt_sh = {sh_ff[6:0], cmd_s};
          if (bit_ff != 4'hf) begin
            nxt_bit = bit_ff + 4'h1;
          end
        end
      end
      ecsl_pkg::eng_decode: begin
        bad = ~(^sh_ff) | (bit_ff != `ECSL_BYTE_BITS);
        if (idx_ff == 3'h0) begin
          bad = bad | i_hdr_bad_use | (i_hdr_len == 3'h0)
              | (i_hdr_len > `ECSL_CMD_MAX_BYTES);
          if (bad) begin
            pay = `ECSL_REPLY_ERR;
          end else if (i_hdr_len == 3'h1) begin
            pay       = i_hdr_reply;
            nxt_valid = 1'b1;
          end else begin
            nxt_idx  = 3'h1;
            nxt_need = i_hdr_len;
            nxt_err  = 1'b0;
            nxt_data = '0;
          end
        end else begin
          bad      = bad | ~sh_ff[`ECSL_DATA_MARK_BIT];
          last     = (idx_ff == need_ff - 3'h1);
          nxt_data = {data_ff[17:0], sh_ff[6:1]};
          if (last) begin
            nxt_idx = 3'h0;
            if (err_ff | bad) begin
              pay = `ECSL_REPLY_ERR;
            end else begin
              pay       = i_hdr_reply;
              nxt_valid = 1'b1;
            end
          end else begin
            nxt_idx = idx_ff + 3'h1;
            nxt_err = err_ff | bad;
            pay     = bad ? `ECSL_REPLY_ERR : `ECSL_REPLY_ZERO;
          end
        end
        nxt_rep = {1'b0, pay, ~(^pay)};
        nxt_st  = ecsl_pkg::eng_reply_wait;
      end
      ecsl_pkg::eng_reply_wait: begin
        if (controller_command_busy_s && !hpw_s) begin
          nxt_bit = 4'h0;
          nxt_st  = ecsl_pkg::eng_reply;
        end
      end
      ecsl_pkg::eng_reply: begin
        if (!controller_command_busy_s || hpw_s) begin
          nxt_st = ecsl_pkg::eng_idle;
        end else if (bit_ff == `ECSL_BYTE_BITS) begin
          nxt_st = ecsl_pkg::eng_idle;
        end else if (rise) begin
          nxt_bit = bit_ff + 4'h1;
        end else if (fall && bit_ff != 4'h0) begin
          nxt_rep = {rep_ff[6:0], 1'b0};
        end
      end
      default: nxt_st = ecsl_pkg::eng_idle;
    endcase
    if (hpw_s) begin
      nxt_idx = 3'h0;
      nxt_st  = ecsl_pkg::eng_idle;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff     <= ecsl_pkg::eng_idle;
      sh_ff     <= 8'h00;
      bit_ff    <= 4'h0;
      idx_ff    <= 3'h0;
      need_ff   <= 3'h0;
      err_ff    <= 1'b0;
      hdr_ff    <= 8'h00;
      data_ff   <= 24'h000000;
      rep_ff    <= 8'h00;
      valid_ff  <= 1'b0;
      sclk_q_ff <= 1'b1;
    end else begin
      st_ff     <= nxt_st;
      sh_ff     <= nxt_sh;
      bit_ff    <= nxt_bit;
      idx_ff    <= nxt_idx;
      need_ff   <= nxt_need;
      err_ff    <= nxt_err;
      hdr_ff    <= nxt_hdr;
      data_ff   <= nxt_data;
      rep_ff    <= nxt_rep;
      valid_ff  <= nxt_valid;
      sclk_q_ff <= sclk_s;
    end
  end

  // Print accept and request intake
  logic acc_n_ff;
  logic nxt_acc_n;
  logic paper_prefeed_request_q_ff;
  logic go_q_ff;
  logic prefeed_ff;
  logic nxt_prefeed;
  logic go_ff;
  logic nxt_go;

  always_comb begin
    nxt_acc_n   = i_operator_call | i_pause_diag | i_wait | i_misprint
                | ~i_engine_ready;
    nxt_prefeed = ~paper_prefeed_request_s & paper_prefeed_request_q_ff & ~acc_n_ff;
    nxt_go      = ~go_s & go_q_ff & ~acc_n_ff;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_n_ff   <= 1'b1;
      paper_prefeed_request_q_ff  <= 1'b1;
      go_q_ff    <= 1'b1;
      prefeed_ff <= 1'b0;
      go_ff      <= 1'b0;
    end else begin
      acc_n_ff   <= nxt_acc_n;
      paper_prefeed_request_q_ff  <= paper_prefeed_request_s;
      go_q_ff    <= go_s;
      prefeed_ff <= nxt_prefeed;
      go_ff      <= nxt_go;
    end
  end

  // Line-sync generator
  logic [15:0] lcnt_ff;
  logic [15:0] nxt_lcnt;
  logic        line_n_ff;
  logic        nxt_line_n;
  logic [15:0] period;

  always_comb begin
    period     = i_dpi_1200 ? 16'(LINE_1200_CYC) : 16'(LINE_600_CYC);
    nxt_lcnt   = (lcnt_ff >= period - 16'h0001) ? 16'h0000 : lcnt_ff + 16'h0001;
    nxt_line_n = ~(nxt_lcnt < 16'(`ECSL_LINE_PULSE_CYC));
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lcnt_ff   <= 16'hffff;
      line_n_ff <= 1'b1;
    end else begin
      lcnt_ff   <= nxt_lcnt;
      line_n_ff <= nxt_line_n;
    end
  end

  assign link.reply_line             = rep_ff[7];
  assign link.engine_reply_busy_n    = (st_ff != ecsl_pkg::eng_reply);
  assign link.engine_power_up_done_n = ~i_engine_ready;
  assign link.print_accept_n         = acc_n_ff;
  assign link.line_sync_n            = line_n_ff;
  assign o_cmd_hdr                   = hdr_ff;
  assign o_cmd_data                  = data_ff;
  assign o_cmd_valid                 = valid_ff;
  assign o_prefeed                   = prefeed_ff;
  assign o_print_go                  = go_ff;
endmodule // ecsl_engine

/* File: rtl/ecsl_ctrl.sv */
// Controller end of the command/status link: sends whole commands byte by
// byte, collects replies, retries on error. Makes the serial clock itself.
`timescale 1ns/1ps
`include "ecsl_consts.svh"
module ecsl_ctrl #(
  parameter int HALF_CYC = (`ECSL_SCLK_MIN_NS + 2 * `ECSL_CLK_NS - 1) / (2 * `ECSL_CLK_NS)
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  ecsl_link_if.ctrl        link,
  input  wire logic        i_host_ready,
  input  wire logic        i_cmd_valid,
  input  wire logic [2:0]  i_cmd_len,
  input  wire logic [39:0] i_cmd_bytes,
  input  wire logic        i_prefeed,
  input  wire logic        i_print_go,
  output logic             o_busy,
  output logic             o_done,
  output logic      [7:0]  o_reply,
  output logic             o_fault,
  output logic             o_engine_ready,
  output logic             o_print_accept,
  output logic             o_line_start
);
  if (HALF_CYC * 2 * `ECSL_CLK_NS < `ECSL_SCLK_MIN_NS || HALF_CYC > 255) begin : g_chk
    $error("ecsl_ctrl: serial clock half period out of range");
  end

  logic engine_reply_busy_s;
  logic sta_s;
  logic ppw_s;
  logic acc_s;
  logic ls_s;

  ecsl_sync #(.WIDTH(5), .RST_VAL(5'h1f)) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_async    ({link.engine_reply_busy_n, link.reply_line, link.engine_power_up_done_n,
                  link.print_accept_n, link.line_sync_n}),
    .o_sync     ({engine_reply_busy_s, sta_s, ppw_s, acc_s, ls_s})
  );

  ecsl_pkg::ecsl_ctl_st_e st_ff;
  ecsl_pkg::ecsl_ctl_st_e nxt_st;
  logic [7:0]  div_ff;
  logic [7:0]  nxt_div;
  logic        sclk_ff;
  logic        nxt_sclk;
  logic        controller_command_busy_ff;
  logic        nxt_controller_command_busy;
  logic [7:0]  sh_ff;
  logic [7:0]  nxt_sh;
  logic [3:0]  bit_ff;
  logic [3:0]  nxt_bit;
  logic [2:0]  idx_ff;
  logic [2:0]  nxt_idx;
  logic [2:0]  len_ff;
  logic [2:0]  nxt_len;
  logic [39:0] bytes_ff;
  logic [39:0] nxt_bytes;
  logic [39:0] wk_ff;
  logic [39:0] nxt_wk;
  logic [1:0]  tries_ff;
  logic [1:0]  nxt_tries;
  logic [7:0]  rep_ff;
  logic [7:0]  nxt_rep;
  logic        done_ff;
  logic        nxt_done;
  logic        fault_ff;
  logic        nxt_fault;
  logic        ls_q_ff;
  logic        ls_pulse_ff;
  logic        tick;
  logic        rep_err;

  assign tick = (div_ff == 8'(HALF_CYC - 1));

  always_comb begin
    nxt_st    = st_ff;
    nxt_div   = tick ? 8'h00 : div_ff + 8'h01;
    nxt_sclk  = sclk_ff;
    nxt_controller_command_busy  = controller_command_busy_ff;
    nxt_sh    = sh_ff;
    nxt_bit   = bit_ff;
    nxt_idx   = idx_ff;
    nxt_len   = len_ff;
    nxt_bytes = bytes_ff;
    nxt_wk    = wk_ff;
    nxt_tries = tries_ff;
    nxt_rep   = rep_ff;
    nxt_done  = 1'b0;
    nxt_fault = fault_ff;
    rep_err   = ~(^rep_ff) | (rep_ff[6:1] == `ECSL_REPLY_ERR);
    case (st_ff)
      ecsl_pkg::ctl_idle: begin
        if (i_cmd_valid && i_cmd_len != 3'h0 && i_cmd_len <= `ECSL_CMD_MAX_BYTES) begin
          nxt_bytes = i_cmd_bytes;
          nxt_wk    = i_cmd_bytes;
          nxt_len   = i_cmd_len;
          nxt_idx   = 3'h0;
          nxt_tries = 2'h0;
          nxt_fault = 1'b0;
          nxt_st    = ecsl_pkg::ctl_wait_free;
        end
      end
      ecsl_pkg::ctl_wait_free: begin
        if (engine_reply_busy_s && !ppw_s && i_host_ready) begin
          nxt_controller_command_busy = 1'b0;
          nxt_sh   = wk_ff[39:32];
          nxt_bit  = 4'h0;
          nxt_div  = 8'h00;
          nxt_st   = ecsl_pkg::ctl_send;
        end
      end
      ecsl_pkg::ctl_send, ecsl_pkg::ctl_recv: begin
        if (tick) begin
          if (sclk_ff) begin
            if (bit_ff == `ECSL_BYTE_BITS) begin
              nxt_controller_command_busy = 1'b1;
              nxt_st   = (st_ff == ecsl_pkg::ctl_send) ? ecsl_pkg::ctl_wait_reply
                                                      : ecsl_pkg::ctl_check;
            end else begin
              nxt_sclk = 1'b0;
              if (bit_ff != 4'h0) begin
                nxt_sh = {sh_ff[6:0], 1'b0};
              end
            end
          end else begin
            nxt_sclk = 1'b1;
            nxt_bit  = bit_ff + 4'h1;
            if (st_ff == ecsl_pkg::ctl_recv) begin
              nxt_rep = {rep_ff[6:0], sta_s};
            end
          end
        end
      end
      ecsl_pkg::ctl_wait_reply: begin
        if (!engine_reply_busy_s) begin
          nxt_bit = 4'h0;
          nxt_div = 8'h00;
          nxt_st  = ecsl_pkg::ctl_recv;
        end
      end
      ecsl_pkg::ctl_check: begin
        if (engine_reply_busy_s) begin
          if (idx_ff != len_ff - 3'h1) begin
            nxt_idx = idx_ff + 3'h1;
            nxt_wk  = {wk_ff[31:0], 8'h00};
            nxt_st  = ecsl_pkg::ctl_wait_free;
          end else if (rep_err && tries_ff != `ECSL_RETRY_MAX) begin
            nxt_tries = tries_ff + 2'h1;
            nxt_idx   = 3'h0;
            nxt_wk    = bytes_ff;
            nxt_st    = ecsl_pkg::ctl_wait_free;
          end else begin
            nxt_fault = rep_err;
            nxt_done  = 1'b1;
            nxt_st    = ecsl_pkg::ctl_idle;
          end
        end
      end
      default: nxt_st = ecsl_pkg::ctl_idle;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff       <= ecsl_pkg::ctl_idle;
      div_ff      <= 8'h00;
      sclk_ff     <= 1'b1;
      controller_command_busy_ff     <= 1'b1;
      sh_ff       <= 8'h00;
      bit_ff      <= 4'h0;
      idx_ff      <= 3'h0;
      len_ff      <= 3'h0;
      bytes_ff    <= 40'h0000000000;
      wk_ff       <= 40'h0000000000;
      tries_ff    <= 2'h0;
      rep_ff      <= 8'h00;
      done_ff     <= 1'b0;
      fault_ff    <= 1'b0;
      ls_q_ff     <= 1'b1;
      ls_pulse_ff <= 1'b0;
    end else begin
      st_ff       <= nxt_st;
      div_ff      <= nxt_div;
      sclk_ff     <= nxt_sclk;
      controller_command_busy_ff     <= nxt_controller_command_busy;
      sh_ff       <= nxt_sh;
      bit_ff      <= nxt_bit;
      idx_ff      <= nxt_idx;
      len_ff      <= nxt_len;
      bytes_ff    <= nxt_bytes;
      wk_ff       <= nxt_wk;
      tries_ff    <= nxt_tries;
      rep_ff      <= nxt_rep;
      done_ff     <= nxt_done;
      fault_ff    <= nxt_fault;
      ls_q_ff     <= ls_s;
      ls_pulse_ff <= ~ls_s & ls_q_ff;
    end
  end

  assign link.serial_clock              = sclk_ff;
  assign link.command_line              = sh_ff[7];
  assign link.controller_command_busy_n = controller_command_busy_ff;
  assign link.host_power_up_done_n      = ~i_host_ready;
  assign link.paper_prefeed_request_n   = ~i_prefeed;
  assign link.print_go_n                = ~i_print_go;
  assign o_busy                         = (st_ff != ecsl_pkg::ctl_idle);
  assign o_done                         = done_ff;
  assign o_reply                        = rep_ff;
  assign o_fault                        = fault_ff;
  assign o_engine_ready                 = ~ppw_s;
  assign o_print_accept                 = ~acc_s;
  assign o_line_start                   = ls_pulse_ff;
endmodule // ecsl_ctrl

/* File: sim/ecsl_link_props.sv */
// Checker on the engine/controller link pins.
// Assumes one core clock domain; instantiated beside the link bundle.
`timescale 1ns/1ps
module ecsl_link_props #(
  parameter int LINE_600_CYC  = 40,
  parameter int LINE_1200_CYC = 20
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic serial_clock,
  input wire logic command_line,
  input wire logic reply_line,
  input wire logic controller_command_busy_n,
  input wire logic engine_reply_busy_n,
  input wire logic host_power_up_done_n,
  input wire logic engine_power_up_done_n,
  input wire logic print_accept_n,
  input wire logic paper_prefeed_request_n,
  input wire logic print_go_n,
  input wire logic line_sync_n
);
  logic       sclk_ff;
  logic       asked_ff;
  logic       lseen_ff;
  logic [3:0] crise_ff;
  logic [3:0] rrise_ff;
  logic [7:0] rsh_ff;
  int         lcnt_ff;
  logic       rise;

  assign rise = serial_clock & ~sclk_ff;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_ff  <= 1'b1;
      asked_ff <= 1'b0;
      lseen_ff <= 1'b0;
      crise_ff <= 4'h0;
      rrise_ff <= 4'h0;
      rsh_ff   <= 8'h00;
      lcnt_ff  <= 0;
    end else begin
      sclk_ff  <= serial_clock;
      crise_ff <= controller_command_busy_n ? 4'h0 : crise_ff + {3'h0, rise};
      rrise_ff <= engine_reply_busy_n ? 4'h0 : rrise_ff + {3'h0, rise};
      if (!engine_reply_busy_n && rise) rsh_ff <= {rsh_ff[6:0], reply_line};
      if ($rose(controller_command_busy_n)) asked_ff <= 1'b1;
      else if ($fell(engine_reply_busy_n)) asked_ff <= 1'b0;
      lcnt_ff <= $fell(line_sync_n) ? 1 : lcnt_ff + 1;
      if ($fell(line_sync_n)) lseen_ff <= 1'b1;
    end
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_sync_low;
    !line_sync_n [*3] ##1 line_sync_n;
  endsequence
  sequence s_power_down;
    engine_power_up_done_n [*4];
  endsequence

  a_sync_pulse: assert property ($fell(line_sync_n) |=> s_sync_low)
    else $error("line sync pulse width wrong");
  a_sync_period: assert property ($fell(line_sync_n) && lseen_ff |->
    lcnt_ff >= LINE_1200_CYC && lcnt_ff <= LINE_600_CYC)
    else $error("line sync period wrong");
  a_accept_power: assert property (s_power_down |-> print_accept_n)
    else $error("accept low while engine not ready");
  a_reply_guard: assert property ($fell(engine_reply_busy_n) |->
    controller_command_busy_n && !host_power_up_done_n)
    else $error("reply busy during command or host down");
  a_reply_cause: assert property ($fell(engine_reply_busy_n) |-> asked_ff)
    else $error("reply without command byte");
  a_cmd_bits: assert property ($rose(controller_command_busy_n) |-> crise_ff == 4'h8)
    else $error("command byte not eight clocks");
  a_reply_bits: assert property ($rose(engine_reply_busy_n) |-> rrise_ff == 4'h8)
    else $error("reply byte not eight clocks");
  a_reply_format: assert property ($rose(engine_reply_busy_n) |->
    !rsh_ff[7] && (^rsh_ff))
    else $error("reply byte format or parity wrong");
  a_sclk_idle: assert property (controller_command_busy_n && engine_reply_busy_n |->
    serial_clock)
    else $error("serial clock not idle high");
endmodule // ecsl_link_props

/* File: sim/ecsl_tb.sv */
// Bench joining engine and controller ends of the link.
// Assumes the rtl files compiled first; header lookup modelled here.
`timescale 1ns/1ps
module ecsl_tb;
  localparam int L6 = 40;
  localparam int L12 = 20;
  typedef struct packed {logic [7:0] r; logic f;} ecsl_exp_s;
  logic        i_core_clk = 1'b0;
  logic        i_rst_b    = 1'b0;
  logic [4:0]  hold = 5'h00;
  logic        dpi = 1'b0, c_valid = 1'b0, pf = 1'b0, go = 1'b0, host_ok = 1'b0;
  logic [2:0]  c_len = 3'h1;
  logic [39:0] c_bytes = 40'h0;
  logic [7:0]  cmd_hdr, reply, h;
  logic [23:0] cmd_data;
  logic        cmd_valid, e_pf, e_go, busy, done, fault, lstart, acc, erdy;
  logic [39:0] bb;
  integer      seed = 94;
  int          fail_count = 0, num_checks = 0, cyc = 0, pf_n = 0, go_n = 0, i, k, n;
  ecsl_exp_s   exp_q[$];
  ecsl_exp_s   e;
  logic [14:0] hdr_q[$];
  logic [14:0] hq;

  ecsl_link_if link_bus ();
  ecsl_engine #(.LINE_600_CYC(L6), .LINE_1200_CYC(L12)) u_ecsl_engine (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .link(link_bus.engine),
    .i_engine_ready(~hold[4]), .i_operator_call(hold[0]), .i_pause_diag(hold[1]),
    .i_wait(hold[2]), .i_misprint(hold[3]), .i_dpi_1200(dpi),
    .i_hdr_len(cmd_hdr[7:5]), .i_hdr_reply(cmd_hdr[6:1]),
    .i_hdr_bad_use(cmd_hdr[4:1] == 4'hf), .o_cmd_hdr(cmd_hdr), .o_cmd_data(cmd_data),
    .o_cmd_valid(cmd_valid), .o_prefeed(e_pf), .o_print_go(e_go));
  ecsl_ctrl u_ecsl_ctrl (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .link(link_bus.ctrl),
    .i_host_ready(host_ok), .i_cmd_valid(c_valid), .i_cmd_len(c_len),
    .i_cmd_bytes(c_bytes), .i_prefeed(pf), .i_print_go(go), .o_busy(busy),
    .o_done(done), .o_reply(reply), .o_fault(fault), .o_engine_ready(erdy),
    .o_print_accept(acc), .o_line_start(lstart));
  ecsl_link_props #(.LINE_600_CYC(L6), .LINE_1200_CYC(L12)) u_ecsl_link_props (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .serial_clock(link_bus.serial_clock), .command_line(link_bus.command_line),
    .reply_line(link_bus.reply_line),
    .controller_command_busy_n(link_bus.controller_command_busy_n),
    .engine_reply_busy_n(link_bus.engine_reply_busy_n),
    .host_power_up_done_n(link_bus.host_power_up_done_n),
    .engine_power_up_done_n(link_bus.engine_power_up_done_n),
    .print_accept_n(link_bus.print_accept_n),
    .paper_prefeed_request_n(link_bus.paper_prefeed_request_n),
    .print_go_n(link_bus.print_go_n), .line_sync_n(link_bus.line_sync_n));

  initial forever #12.5 i_core_clk = ~i_core_clk;

  function automatic logic [7:0] mk(input logic [6:0] x);
    return {x, ~^x};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    chk(exp_q.size(), 0);
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Whole command; expected reply and fault noted before it starts
  task automatic send(input logic [2:0] len, input logic [7:0] r, input logic f);
    exp_q.push_back('{r, f});
    if (!f) hdr_q.push_back({bb[39:32], len > 3'h1, 6'((bb >> (40 - 8 * len)) >> 1)});
    @(posedge i_core_clk);
    c_valid <= 1'b1;
    c_len   <= len;
    c_bytes <= bb;
    k = 0;
    do @(negedge i_core_clk); while (busy !== 1'b1 && ++k < 50);
    @(posedge i_core_clk) c_valid <= 1'b0;
    k = 0;
    do @(negedge i_core_clk); while (busy !== 1'b0 && ++k < 40000);
    repeat (4) @(negedge i_core_clk);
  endtask

  task automatic line_meas(output int cnt);
    k = 0;
    do @(negedge i_core_clk); while (lstart !== 1'b1 && ++k < 200);
    cnt = 0;
    do begin @(negedge i_core_clk); cnt++; end while (lstart !== 1'b1 && cnt < 200);
  endtask

  always @(posedge i_core_clk) begin
    cyc++;
    if (done === 1'b1) begin
      e = exp_q.pop_front();
      chk({reply, fault}, e);
    end
    if (cmd_valid === 1'b1) begin
      hq = hdr_q.pop_front();
      chk(cmd_hdr, hq[14:7]);
      if (hq[6]) chk(cmd_data[5:0], hq[5:0]);
    end
    pf_n += (e_pf === 1'b1);
    go_n += (e_go === 1'b1);
    if (cyc == 90000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    repeat (6) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    // Host down: no command or reply may move on the link until it comes up
    bb = {mk(7'h12), 32'h0};
    fork
      send(3'h1, mk(7'h12), 1'b0);
      begin
        repeat (300) @(negedge i_core_clk);
        chk({link_bus.controller_command_busy_n, link_bus.engine_reply_busy_n}, 2'h3);
        @(posedge i_core_clk) host_ok <= 1'b1;
      end
    join
    $display("test host power-up done");
    for (i = 0; i < 5; i++) begin
      h  = mk({3'(1 + i % 5), 4'($random(seed)) & 4'h7});
      bb = {h, mk({1'b1, 6'($random(seed))}), mk({1'b1, 6'($random(seed))}),
            mk({1'b1, 6'($random(seed))}), mk({1'b1, 6'($random(seed))})};
      send(3'(1 + i % 5), mk({1'b0, h[6:1]}), 1'b0);
    end
    $display("test good commands done");
    bb = {mk(7'h02), 32'h0};
    send(3'h1, 8'h7f, 1'b1);
    bb = {mk(7'h1f), 32'h0};
    send(3'h1, 8'h7f, 1'b1);
    bb = {mk(7'h21), mk(7'h55) ^ 8'h01, 24'h0};
    send(3'h2, 8'h7f, 1'b1);
    bb = {mk(7'h23), mk(7'h15), 24'h0};
    send(3'h2, 8'h7f, 1'b1);
    bb = {mk(7'h31), mk(7'h4a) ^ 8'h01, mk(7'h4b), 16'h0};
    send(3'h3, 8'h7f, 1'b1);
    $display("test error commands done");
    for (i = 0; i < 6; i++) begin
      @(posedge i_core_clk) hold <= (i < 5) ? 5'(5'h01 << i) : 5'h00;
      repeat (30) @(negedge i_core_clk);
      chk(link_bus.print_accept_n, i < 5);
      chk({acc, erdy}, {i == 5, i != 4});
      pf_n = 0;
      go_n = 0;
      @(posedge i_core_clk) begin pf <= 1'b1; go <= 1'b1; end
      repeat (10) @(posedge i_core_clk);
      pf <= 1'b0;
      go <= 1'b0;
      repeat (10) @(negedge i_core_clk);
      chk(pf_n, i == 5);
      chk(go_n, i == 5);
    end
    $display("test accept gating done");
    line_meas(n);
    chk(n, L6);
    @(posedge i_core_clk) dpi <= 1'b1;
    line_meas(n);
    line_meas(n);
    chk(n, L12);
    $display("test line sync done");
    test_done();
  end
endmodule // ecsl_tb
